// file: pkg/eewc_pkg.sv
package eewc_pkg;
    localparam logic [7:0] OPCODE_WRITE     = 8'h12;
    localparam int         ZONE_LONG_BIT    = 7;
    localparam int         ZONE_ENC_BIT     = 6;
    localparam logic [7:0] ZONE_RSVD_MASK   = 8'h3C;
    localparam int         ZONE_SEL_W       = 2;
    localparam int         CFG_ENC_BIT      = 14;
    localparam int         CFG_WKEY_LSB     = 8;
    localparam int         SLOT_W           = 4;
    localparam int         SHORT_BYTES      = 4;
    localparam int         LONG_BYTES       = 32;
    localparam int         MAC_BYTES        = 32;
    localparam int         HDR_BYTES        = 4;
    localparam int         DIGEST_BYTES     = 32;
    localparam int         MSG_OPC_IDX      = 32;
    localparam int         MSG_P1_IDX       = 33;
    localparam int         MSG_P2L_IDX      = 34;
    localparam int         MSG_P2H_IDX      = 35;
    localparam int         MSG_SN8_IDX      = 36;
    localparam int         MSG_SN0_IDX      = 37;
    localparam int         MSG_SN1_IDX      = 38;
    localparam int         MSG_PAD_BYTES    = 25;
    localparam int         MSG_DATA_IDX     = 64;
    localparam logic [7:0] RSP_OK           = 8'h00;
    localparam logic [7:0] RSP_MAC_FAIL     = 8'h01;
    localparam logic [7:0] RSP_PARSE_ERR    = 8'h03;
    localparam logic [7:0] RSP_EXEC_ERR     = 8'h0F;
endpackage

// file: pkg/eewc_link_if.sv
interface eewc_link_if;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       byte_last;
    logic       byte_ready;
    logic       rsp_valid;
    logic [7:0] rsp_data;

    modport dev (
        input  byte_valid, byte_data, byte_last,
        output byte_ready, rsp_valid, rsp_data
    );
    modport host (
        output byte_valid, byte_data, byte_last,
        input  byte_ready, rsp_valid, rsp_data
    );
endinterface

// file: rtl/eewc_dev.sv
module eewc_dev (
    // Clock, reset, enable
    input  wire logic                   MCLK_I,
    input  wire logic                   NRST_I,
    input  wire logic                   CE_I,
    // Link
    eewc_link_if.dev                    LINK,
    // Session digest state
    input  wire logic [255:0]           SESSION_DIGEST_I,
    input  wire logic                   DIGEST_VALID_I,
    input  wire logic                   DIGEST_FROM_GEN_I,
    input  wire logic [eewc_pkg::SLOT_W-1:0] DIGEST_SOURCE_SLOT_I,
    // Device state
    input  wire logic                   DATA_LOCKED_I,
    input  wire logic [15:0]            SLOT_CFG_WORD_I,
    input  wire logic [5:0]             BLOCK_VALID_BYTES_I,
    input  wire logic [7:0]             SN8_I,
    input  wire logic [15:0]            SN01_I,
    // Hash engine
    output logic                        HASH_VALID_O,
    output logic [7:0]                  HASH_BYTE_O,
    output logic                        HASH_LAST_O,
    input  wire logic                   HASH_DONE_I,
    input  wire logic [255:0]           HASH_DIGEST_I,
    // EEPROM write port
    output logic                        EE_WR_O,
    output logic [1:0]                  EE_ZONE_O,
    output logic [15:0]                 EE_ADDR_O,
    output logic                        EE_LONG_O,
    output logic [255:0]                EE_DATA_O,
    output logic [31:0]                 EE_MASK_O
);
    import eewc_pkg::*;

    typedef enum logic [5:0] {
        ST_RX   = 6'b00_0001,
        ST_CHK  = 6'b00_0010,
        ST_HASH = 6'b00_0100,
        ST_WAIT = 6'b00_1000,
        ST_WR   = 6'b01_0000,
        ST_RSP  = 6'b10_0000
    } eewc_state_t;

    eewc_state_t  state_reg, state_next;
    logic [6:0]   cnt_reg;
    logic         ovf_reg;
    logic [7:0]   opc_reg, p1_reg;
    logic [15:0]  addr_reg;
    logic [255:0] data_reg, mac_reg;
    logic [7:0]   rsp_reg;
    logic [6:0]   hcnt_reg;
    logic         frame_end, enc, mac_there, long_w, key_ok, hdr_ok, len_ok;
    logic [6:0]   dlen, msg_len;
    logic [255:0] plain;
    logic [31:0]  mask;
    logic [7:0]   msg_byte;

    assign frame_end = LINK.byte_valid && LINK.byte_ready && LINK.byte_last;
    assign long_w    = p1_reg[ZONE_LONG_BIT];
    assign dlen      = long_w ? 7'(LONG_BYTES) : 7'(SHORT_BYTES);
    assign mac_there = (cnt_reg == dlen + 7'(HDR_BYTES + MAC_BYTES));
    assign len_ok    = !ovf_reg && (mac_there || cnt_reg == dlen + 7'(HDR_BYTES));
    assign hdr_ok    = (opc_reg == OPCODE_WRITE)
                    && ((p1_reg & ZONE_RSVD_MASK) == 8'h00);
    // Encryption source depends on lock state
    assign enc = DATA_LOCKED_I ? SLOT_CFG_WORD_I[CFG_ENC_BIT]
                               : p1_reg[ZONE_ENC_BIT];
    // Key random/authorization fields are deliberately not inputs
    assign key_ok = DATA_LOCKED_I
        ? (DIGEST_VALID_I && DIGEST_FROM_GEN_I
           && DIGEST_SOURCE_SLOT_I == SLOT_CFG_WORD_I[CFG_WKEY_LSB +: SLOT_W])
        : DIGEST_VALID_I;
    assign msg_len = 7'(MSG_DATA_IDX) + dlen;

    genvar gi;
    generate
        for (gi = 0; gi < LONG_BYTES; gi++) begin : g_byte
            assign plain[8*gi +: 8] = enc ? data_reg[8*gi +: 8] ^ SESSION_DIGEST_I[8*gi +: 8]
                                          : data_reg[8*gi +: 8];
            assign mask[gi] = (gi < SHORT_BYTES || long_w)
                              && (6'(gi) < BLOCK_VALID_BYTES_I || !(enc && long_w));
        end
    endgenerate

    always_comb begin
        msg_byte = 8'h00;
        if (hcnt_reg < 7'(DIGEST_BYTES)) begin
            msg_byte = SESSION_DIGEST_I[8*hcnt_reg[4:0] +: 8];
        end else if (hcnt_reg == 7'(MSG_OPC_IDX)) begin
            msg_byte = opc_reg;
        end else if (hcnt_reg == 7'(MSG_P1_IDX)) begin
            msg_byte = p1_reg;
        end else if (hcnt_reg == 7'(MSG_P2L_IDX)) begin
            msg_byte = addr_reg[7:0];
        end else if (hcnt_reg == 7'(MSG_P2H_IDX)) begin
            msg_byte = addr_reg[15:8];
        end else if (hcnt_reg == 7'(MSG_SN8_IDX)) begin
            msg_byte = SN8_I;
        end else if (hcnt_reg == 7'(MSG_SN0_IDX)) begin
            msg_byte = SN01_I[7:0];
        end else if (hcnt_reg == 7'(MSG_SN1_IDX)) begin
            msg_byte = SN01_I[15:8];
        end else if (hcnt_reg >= 7'(MSG_DATA_IDX)) begin
            msg_byte = plain[8*hcnt_reg[4:0] +: 8];
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RX:   if (frame_end) state_next = ST_CHK;
            ST_CHK: begin
                if (!len_ok || !hdr_ok) begin
                    state_next = ST_RSP;
                end else if (enc && (!mac_there || !long_w || !key_ok)) begin
                    state_next = ST_RSP;
                end else if (mac_there) begin
                    state_next = ST_HASH;
                end else begin
                    state_next = ST_WR;
                end
            end
            ST_HASH: if (hcnt_reg == msg_len - 7'd1) state_next = ST_WAIT;
            ST_WAIT: if (HASH_DONE_I) state_next = (HASH_DIGEST_I == mac_reg) ? ST_WR : ST_RSP;
            ST_WR:   state_next = ST_RSP;
            ST_RSP:  state_next = ST_RX;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_reg <= ST_RX;
        end else if (CE_I) begin
            state_reg <= state_next;
        end
    end

    function automatic logic [6:0] dlen_rx(input logic [6:0] c, input logic [7:0] p1,
                                           input logic [7:0] b);
        logic [7:0] z;
        z = (c == 7'd1) ? b : p1;
        return z[ZONE_LONG_BIT] ? 7'(LONG_BYTES) : 7'(SHORT_BYTES);
    endfunction

    // Frame capture
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cnt_reg  <= 7'd0;
            ovf_reg  <= 1'b0;
            opc_reg  <= 8'h00;
            p1_reg   <= 8'h00;
            addr_reg <= 16'h0000;
            data_reg <= '0;
            mac_reg  <= '0;
        end else if (CE_I) begin
            if (state_reg == ST_RSP) begin
                cnt_reg <= 7'd0;
                ovf_reg <= 1'b0;
            end else if (LINK.byte_valid && LINK.byte_ready) begin
                if (cnt_reg == 7'd0) opc_reg <= LINK.byte_data;
                if (cnt_reg == 7'd1) p1_reg <= LINK.byte_data;
                if (cnt_reg == 7'd2) addr_reg[7:0] <= LINK.byte_data;
                if (cnt_reg == 7'd3) addr_reg[15:8] <= LINK.byte_data;
                if (cnt_reg >= 7'(HDR_BYTES) && cnt_reg < 7'(HDR_BYTES + LONG_BYTES)) begin
                    data_reg[8*(cnt_reg - 7'(HDR_BYTES)) +: 8] <= LINK.byte_data;
                end
                if (cnt_reg >= 7'(HDR_BYTES) + dlen_rx(cnt_reg, p1_reg, LINK.byte_data)
                    && !ovf_reg && cnt_reg != 7'h7F) begin
                    mac_reg[8*5'(cnt_reg - 7'(HDR_BYTES) - dlen) +: 8] <= LINK.byte_data;
                end
                if (cnt_reg == 7'(HDR_BYTES + LONG_BYTES + MAC_BYTES)) begin
                    ovf_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 7'd1;
                end
            end
        end
    end

    // Hash message stream
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            hcnt_reg     <= 7'd0;
            HASH_VALID_O <= 1'b0;
            HASH_BYTE_O  <= 8'h00;
            HASH_LAST_O  <= 1'b0;
        end else if (CE_I) begin
            HASH_VALID_O <= (state_reg == ST_HASH);
            HASH_LAST_O  <= (state_reg == ST_HASH) && (hcnt_reg == msg_len - 7'd1);
            HASH_BYTE_O  <= (state_reg == ST_HASH) ? msg_byte : 8'h00;
            hcnt_reg     <= (state_reg == ST_HASH) ? hcnt_reg + 7'd1 : 7'd0;
        end
    end

    // EEPROM store and response
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            EE_WR_O   <= 1'b0;
            EE_ZONE_O <= 2'b00;
            EE_ADDR_O <= 16'h0000;
            EE_LONG_O <= 1'b0;
            EE_DATA_O <= '0;
            EE_MASK_O <= 32'h0000_0000;
            rsp_reg   <= RSP_OK;
        end else if (CE_I) begin
            EE_WR_O <= (state_reg == ST_WR);
            if (state_reg == ST_WR) begin
                EE_ZONE_O <= p1_reg[ZONE_SEL_W-1:0];
                EE_ADDR_O <= addr_reg;
                EE_LONG_O <= long_w;
                EE_DATA_O <= plain;
                EE_MASK_O <= mask;
            end
            if (state_reg == ST_CHK) begin
                rsp_reg <= (!len_ok || !hdr_ok) ? RSP_PARSE_ERR : RSP_EXEC_ERR;
            end else if (state_reg == ST_WAIT && HASH_DONE_I) begin
                rsp_reg <= RSP_MAC_FAIL;
            end else if (state_reg == ST_WR) begin
                rsp_reg <= RSP_OK;
            end
        end
    end

    assign LINK.byte_ready = (state_reg == ST_RX) && CE_I;
    assign LINK.rsp_valid  = (state_reg == ST_RSP) && CE_I;
    assign LINK.rsp_data   = rsp_reg;
endmodule

// file: rtl/eewc_host.sv
module eewc_host #(
    parameter int MAX_BYTES = 68
) (
    // Clock, reset, enable
    input  wire logic         MCLK_I,
    input  wire logic         NRST_I,
    input  wire logic         CE_I,
    // Link
    eewc_link_if.host         LINK,
    // Command request
    input  wire logic         START_I,
    input  wire logic [7:0]   ZONE_I,
    input  wire logic [15:0]  ADDR_I,
    input  wire logic [255:0] DATA_I,
    input  wire logic         ENCRYPT_I,
    input  wire logic [255:0] DIGEST_I,
    input  wire logic         SEND_MAC_I,
    input  wire logic [255:0] MAC_I,
    // Command result
    output logic              BUSY_O,
    output logic              DONE_O,
    output logic [7:0]        RSP_O
);
    import eewc_pkg::*;

    if (MAX_BYTES != HDR_BYTES + LONG_BYTES + MAC_BYTES) begin : g_bad_max
        $error("MAX_BYTES unsupported");
    end

    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_SEND = 3'b010,
        HS_WAIT = 3'b100
    } eewc_hstate_t;

    eewc_hstate_t state_reg;
    logic [6:0]   cnt_reg, total_reg;
    logic [7:0]   zone_reg;
    logic [15:0]  addr_reg;
    logic [255:0] data_reg, mac_reg;
    logic [6:0]   dlen, di, mi;
    logic [7:0]   tx_byte;

    assign dlen = zone_reg[ZONE_LONG_BIT] ? 7'(LONG_BYTES) : 7'(SHORT_BYTES);
    assign di   = cnt_reg - 7'(HDR_BYTES);
    assign mi   = cnt_reg - 7'(HDR_BYTES) - dlen;

    always_comb begin
        tx_byte = 8'h00;
        if (cnt_reg == 7'd0) begin
            tx_byte = OPCODE_WRITE;
        end else if (cnt_reg == 7'd1) begin
            tx_byte = zone_reg;
        end else if (cnt_reg == 7'd2) begin
            tx_byte = addr_reg[7:0];
        end else if (cnt_reg == 7'd3) begin
            tx_byte = addr_reg[15:8];
        end else if (cnt_reg < 7'(HDR_BYTES) + dlen) begin
            tx_byte = data_reg[8*di[4:0] +: 8];
        end else begin
            tx_byte = mac_reg[8*mi[4:0] +: 8];
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_reg <= HS_IDLE;
            cnt_reg   <= 7'd0;
            total_reg <= 7'd0;
            zone_reg  <= 8'h00;
            addr_reg  <= 16'h0000;
            data_reg  <= '0;
            mac_reg   <= '0;
        end else if (CE_I) begin
            unique case (state_reg)
                HS_IDLE: if (START_I) begin
                    state_reg <= HS_SEND;
                    cnt_reg   <= 7'd0;
                    zone_reg  <= (ZONE_I & ~ZONE_RSVD_MASK)
                               | (ENCRYPT_I ? 8'h40 : 8'h00)
                               | (ENCRYPT_I ? 8'h80 : 8'h00);
                    addr_reg  <= ADDR_I;
                    data_reg  <= ENCRYPT_I ? DATA_I ^ DIGEST_I : DATA_I;
                    mac_reg   <= MAC_I;
                    total_reg <= 7'(HDR_BYTES)
                               + ((ZONE_I[ZONE_LONG_BIT] || ENCRYPT_I) ? 7'(LONG_BYTES)
                                                                       : 7'(SHORT_BYTES))
                               + ((SEND_MAC_I || ENCRYPT_I) ? 7'(MAC_BYTES) : 7'd0);
                end
                HS_SEND: if (LINK.byte_ready) begin
                    cnt_reg <= cnt_reg + 7'd1;
                    if (cnt_reg == total_reg - 7'd1) state_reg <= HS_WAIT;
                end
                HS_WAIT: if (LINK.rsp_valid) state_reg <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            DONE_O <= 1'b0;
            RSP_O  <= 8'h00;
        end else if (CE_I) begin
            DONE_O <= (state_reg == HS_WAIT) && LINK.rsp_valid;
            if ((state_reg == HS_WAIT) && LINK.rsp_valid) RSP_O <= LINK.rsp_data;
        end
    end

    assign BUSY_O          = (state_reg != HS_IDLE);
    assign LINK.byte_valid = (state_reg == HS_SEND);
    assign LINK.byte_data  = tx_byte;
    assign LINK.byte_last  = (state_reg == HS_SEND) && (cnt_reg == total_reg - 7'd1);
endmodule

// file: bench/eewc_assertions.sv
module eewc_assertions (
    // Clock and reset
    input  wire logic       MCLK_I,
    input  wire logic       NRST_I,
    // Link signals
    input  wire logic       byte_valid,
    input  wire logic [7:0] byte_data,
    input  wire logic       byte_last,
    input  wire logic       byte_ready,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import eewc_pkg::*;

    logic       take;
    logic [6:0] cnt_reg;
    logic [7:0] zone_reg;
    logic       pend_reg;

    assign take = byte_valid && byte_ready;

    // Byte count within the frame
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cnt_reg <= '0;
        end else if (rsp_valid) begin
            cnt_reg <= '0;
        end else if (take) begin
            cnt_reg <= cnt_reg + 7'd1;
        end
    end

    // Zone byte of the frame
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            zone_reg <= '0;
        end else if (take && cnt_reg == 7'd1) begin
            zone_reg <= byte_data;
        end
    end

    // Answer owed
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pend_reg <= 1'b0;
        end else if (take && byte_last) begin
            pend_reg <= 1'b1;
        end else if (rsp_valid) begin
            pend_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_take_last;
        take && byte_last;
    endsequence
    sequence s_answer;
        ##[0:199] rsp_valid;
    endsequence

    property p_first_opcode;
        take && cnt_reg == 7'd0 |-> byte_data == OPCODE_WRITE;
    endproperty
    a_first_opcode: assert property (p_first_opcode)
        else $error("first byte is not the write opcode");
    property p_frame_len;
        s_take_last |-> (zone_reg[7] ? (cnt_reg == 7'd35 || cnt_reg == 7'd67)
                                     : (cnt_reg == 7'd7 || cnt_reg == 7'd39));
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame length does not match zone length bit");
    property p_rsvd_err;
        rsp_valid && |(zone_reg & ZONE_RSVD_MASK) |-> rsp_data == RSP_PARSE_ERR;
    endproperty
    a_rsvd_err: assert property (p_rsvd_err)
        else $error("reserved zone bits not refused");
    property p_ok_clean;
        rsp_valid && rsp_data == RSP_OK |-> !(|(zone_reg & ZONE_RSVD_MASK));
    endproperty
    a_ok_clean: assert property (p_ok_clean)
        else $error("success with reserved zone bits");
    property p_rsp_pulse;
        rsp_valid |=> !rsp_valid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response longer than one byte");
    property p_rsp_owed;
        rsp_valid |-> pend_reg;
    endproperty
    a_rsp_owed: assert property (p_rsp_owed)
        else $error("response without a frame");
    property p_quiet_wait;
        s_take_last |=> (!byte_ready) throughout s_answer;
    endproperty
    a_quiet_wait: assert property (p_quiet_wait)
        else $error("no answer in time or bytes taken while busy");
    property p_short_walk;
        s_take_last ##0 (cnt_reg == 7'd7 && !zone_reg[6] && !(|(zone_reg & ZONE_RSVD_MASK)))
            |=> !rsp_valid ##1 !rsp_valid ##1 (rsp_valid && rsp_data == RSP_OK);
    endproperty
    a_short_walk: assert property (p_short_walk)
        else $error("plain word write answer not on third cycle");
    property p_hold;
        byte_valid && !byte_ready |=> byte_valid && $stable(byte_data) && $stable(byte_last);
    endproperty
    a_hold: assert property (p_hold)
        else $error("command byte changed before it was taken");
endmodule

// file: bench/tb_top.sv
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import eewc_pkg::*;

    localparam logic [255:0] D1 = {4{64'h0F1E_2D3C_4B5A_6978}};
    logic [255:0] dg = {8{32'h1357_9BDF}};
    logic [255:0] hd = {8{32'h6A09_E667}};
    logic [255:0] data = D1;
    logic [255:0] mac = '0;
    logic [15:0] addr = 16'h0028;
    logic [15:0] cfg = 16'h4500;
    logic [15:0] sn01 = 16'hBB01;
    logic [7:0] sn8 = 8'hEE;
    logic [7:0] zone = '0;
    logic [3:0] src = '0;
    logic [5:0] bvb = 6'd32;
    logic clk = 0, nrst = 0, start = 0, enc = 0, smac = 0, dv = 0, dgen = 0, lock = 0, hdone = 0;
    logic busy, done, hv, hl, ewr, el;
    logic [7:0] rsp, hb;
    logic [1:0] ez;
    logic [15:0] ea;
    logic [255:0] ed;
    logic [31:0] em;
    logic [7:0] hq[$];
    logic [7:0] lq[$];
    int checks = 0, fail_count = 0, wrn = 0, w0 = 0;
    logic dce = 1'b1;
    int hold_cnt = 0;

    always #12.5 clk = ~clk;

    eewc_link_if u_eewc_link_if ();
    eewc_host u_eewc_host (.MCLK_I(clk), .NRST_I(nrst), .CE_I(1'b1), .LINK(u_eewc_link_if),
        .START_I(start), .ZONE_I(zone), .ADDR_I(addr), .DATA_I(data), .ENCRYPT_I(enc),
        .DIGEST_I(dg), .SEND_MAC_I(smac), .MAC_I(mac), .BUSY_O(busy), .DONE_O(done),
        .RSP_O(rsp));
    eewc_dev u_eewc_dev (.MCLK_I(clk), .NRST_I(nrst), .CE_I(dce), .LINK(u_eewc_link_if),
        .SESSION_DIGEST_I(dg), .DIGEST_VALID_I(dv), .DIGEST_FROM_GEN_I(dgen),
        .DIGEST_SOURCE_SLOT_I(src), .DATA_LOCKED_I(lock), .SLOT_CFG_WORD_I(cfg),
        .BLOCK_VALID_BYTES_I(bvb), .SN8_I(sn8), .SN01_I(sn01), .HASH_VALID_O(hv),
        .HASH_BYTE_O(hb), .HASH_LAST_O(hl), .HASH_DONE_I(hdone), .HASH_DIGEST_I(hd),
        .EE_WR_O(ewr), .EE_ZONE_O(ez), .EE_ADDR_O(ea), .EE_LONG_O(el), .EE_DATA_O(ed),
        .EE_MASK_O(em));
    eewc_assertions u_eewc_assertions (.MCLK_I(clk), .NRST_I(nrst),
        .byte_valid(u_eewc_link_if.byte_valid), .byte_data(u_eewc_link_if.byte_data),
        .byte_last(u_eewc_link_if.byte_last), .byte_ready(u_eewc_link_if.byte_ready),
        .rsp_valid(u_eewc_link_if.rsp_valid), .rsp_data(u_eewc_link_if.rsp_data));

    // Hash engine stand-in and traffic capture
    always @(posedge clk) begin
        hdone <= hv && hl;
        if (hv) hq.push_back(hb);
        if (u_eewc_link_if.byte_valid && u_eewc_link_if.byte_ready) begin
            lq.push_back(u_eewc_link_if.byte_data);
        end
        if (ewr) wrn++;
        // Freeze the device once for four cycles on the fourth command byte
        if (!dce) hold_cnt++;
        dce <= !(lq.size() == 3 && hold_cnt < 4);
    end

    task automatic end_of_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic run(input logic [7:0] z, input logic e, input logic m, input logic [255:0] mv);
        int n;
        hq.delete();
        lq.delete();
        w0 = wrn;
        zone <= z;
        enc <= e;
        smac <= m;
        mac <= mv;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK("done", 1'b1, done)
    endtask

    task automatic outcome(input string t, input logic [7:0] r, input int wd);
        `CHK("rsp", r, rsp)
        `CHK("wr_count", wd, wrn - w0)
        $display("%s done", t);
    endtask

    task automatic msgchk(input logic [7:0] z);
        logic [767:0] ev, gv;
        ev = '0;
        gv = '0;
        ev[255:0] = dg;
        ev[311:256] = {sn01, sn8, addr, z, OPCODE_WRITE};
        ev[767:512] = D1;
        foreach (hq[i]) if (i < 96) gv[8*i +: 8] = hq[i];
        `CHK("hash_len", 96, hq.size())
        `CHK("hash_msg", ev, gv)
    endtask

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        dv <= 1'b1;
        src <= 4'd9;
        run(8'h02, 1'b0, 1'b0, '0);
        outcome("plain_short", RSP_OK, 1);
        `CHK("stall", 4, hold_cnt)
        `CHK("ee_word", D1[31:0], ed[31:0])
        `CHK("ee_addr", addr, ea)
        `CHK("ee_zone", 2'd2, ez)
        `CHK("ee_long", 1'b0, el)
        `CHK("opcode", OPCODE_WRITE, lq[0])
        run(8'h02, 1'b1, 1'b1, hd);
        outcome("enc_unlocked", RSP_OK, 1);
        `CHK("ee_plain", D1, ed)
        `CHK("cipher", D1[7:0] ^ dg[7:0], lq[4])
        `CHK("ee_mask", 32'hFFFF_FFFF, em)
        `CHK("ee_long", 1'b1, el)
        msgchk(8'hC2);
        run(8'h02, 1'b1, 1'b1, ~hd);
        outcome("bad_mac", RSP_MAC_FAIL, 0);
        run(8'h02, 1'b1, 1'b0, '0);
        outcome("forced_mac", RSP_MAC_FAIL, 0);
        `CHK("mac_sent", 68, lq.size())
        run(8'hC2, 1'b0, 1'b0, '0);
        outcome("no_mac", RSP_EXEC_ERR, 0);
        run(8'h06, 1'b0, 1'b0, '0);
        outcome("rsvd_zone", RSP_OK, 1);
        `CHK("zone_sent", 8'h02, lq[1])
        lock <= 1'b1;
        dgen <= 1'b1;
        src <= 4'd5;
        bvb <= 6'd8;
        run(8'h02, 1'b1, 1'b1, hd);
        outcome("enc_locked", RSP_OK, 1);
        `CHK("ee_mask", 32'h0000_00FF, em)
        `CHK("ee_plain", D1[63:0], ed[63:0])
        for (int k = 0; k < 3; k++) begin
            src <= (k == 0) ? 4'd4 : 4'd5;
            dgen <= (k != 1);
            dv <= (k != 2);
            run(8'h02, 1'b1, 1'b1, hd);
            outcome("key_check", RSP_EXEC_ERR, 0);
        end
        dv <= 1'b1;
        cfg <= 16'h0500;
        run(8'h42, 1'b0, 1'b0, '0);
        outcome("locked_plain", RSP_OK, 1);
        `CHK("ee_word", D1[31:0], ed[31:0])
        end_of_test();
    end

    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
endmodule
